/* inc/ovt_pkg.sv */
/*
 * Constants, settings layout and register map for the overvoltage trip timing stage.
 * Assumes one 250 MHz clock and a program-cycle tick derived from it inside the stage.
 */
// Operation
// - Sample blocking at each program-cycle start
// - Unblocked pick-up asserts start, begins timing
// - Blocked pick-up asserts blocked, no timing; timer still advances within release delay when cont and trst are YES
// - Blocking drops start, release handling follows
// - Blocking activation raises panel and event
// - Forcing mode lets software drive blocking
// - Instant mode trips with start
// - Fixed delay trips after continuous pick-up
// - Inverse time k over ratio power minus one
// - Delay type 1 fixed, 2 inverse
// - Fixed delay step 5 ms, zero instant
// - Dial k step 10 ms, inverse only
// - Exponent a default 1.00, inverse only
// - Release delay step 5 ms default 60 ms
// - Timer reset after full release delay
// - Optionally keep timing during release
// - No trip during release without re-pick-up
// - Defaults hold timer during release
// - Remaining time readout counts down
// - Voltage ratio readouts at 0.01 resolution
// - Pick-up above threshold, reset below 97 %
// - Criterion one, two or three voltages
// - Instant start and trip share stamp
package ovt_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ        = 250;
    localparam int TICK_US        = 5000;
    localparam int TICK_CYCLES    = TICK_US * CLK_MHZ;
    localparam int STAMP_US       = 1000;
    localparam int STAMP_CYCLES   = STAMP_US * CLK_MHZ;
    localparam int BLOCK_LEAD_MS  = 5;
    localparam logic [19:0] MAX_TICKS = 20'h5_7E40;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_MODE   = 8'h00;
    localparam logic [7:0] OFF_FIXED  = 8'h04;
    localparam logic [7:0] OFF_DIAL   = 8'h08;
    localparam logic [7:0] OFF_EXPO   = 8'h0C;
    localparam logic [7:0] OFF_REL    = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_EXPECT = 8'h18;
    localparam logic [7:0] OFF_REMAIN = 8'h1C;
    localparam logic [7:0] OFF_RATIO  = 8'h20;
    localparam logic [7:0] OFF_RATIOM = 8'h24;
    localparam logic [7:0] OFF_STAMP  = 8'h28;
    // ----------------------------------------------------------------
    // Mode register fields and resets
    // ----------------------------------------------------------------
    localparam int F_DTYPE  = 0;
    localparam int F_DREL   = 2;
    localparam int F_TRST   = 4;
    localparam int F_CONT   = 6;
    localparam int F_CRIT   = 8;
    localparam int F_FORCE  = 10;
    localparam int F_SWBLK  = 11;
    localparam logic [1:0] CODE_NO    = 2'h1;
    localparam logic [1:0] CODE_YES   = 2'h2;
    localparam logic [1:0] DT_FIXED   = 2'h1;
    localparam logic [1:0] DT_INVERSE = 2'h2;
    localparam logic [31:0] RST_MODE  = 32'h0000_0065;
    localparam logic [15:0] RST_FIXED = 16'h0008;
    localparam logic [15:0] RST_DIAL  = 16'h0005;
    localparam logic [15:0] RST_EXPO  = 16'h0064;
    localparam logic [15:0] RST_REL   = 16'h000C;
    localparam logic [15:0] RATIO_ONE = 16'h0064;
    localparam logic [15:0] RESET_PCT = 16'h0061;

    typedef struct packed {
        logic [15:0] ua;
        logic [15:0] ub;
        logic [15:0] uc;
    } volt_s;
endpackage : ovt_pkg

/* src/ovt_stage.sv */
/*
 * Overvoltage stage: pick-up, blocking, fixed/inverse trip timing, release handling.
 * Assumes voltages in hundredths of a percent-of-nominal threshold unit, same clock domain,
 * and a classic Wishbone master for settings and readouts.
 */
`timescale 1ns/100ps
module ovt_stage #(
    parameter int TICK_CYC  = ovt_pkg::TICK_CYCLES,
    parameter int STAMP_CYC = ovt_pkg::STAMP_CYCLES
) (
    // Clock and reset
    input  wire logic            MCLK_I,
    input  wire logic            RESET_I,
    // Wishbone slave
    input  wire logic            WB_CYC_I,
    input  wire logic            WB_STB_I,
    input  wire logic            WB_WE_I,
    input  wire logic [7:0]      WB_ADR_I,
    input  wire logic [3:0]      WB_SEL_I,
    input  wire logic [31:0]     WB_DAT_I,
    output logic      [31:0]     WB_DAT_O,
    output logic                 WB_ACK_O,
    // Measurement and blocking
    input  wire ovt_pkg::volt_s  VOLT_I,
    input  wire logic [15:0]     USET_I,
    input  wire logic            BLOCK_PIN_I,
    // Stage outputs
    output logic                 START_O,
    output logic                 TRIP_O,
    output logic                 BLOCKED_O,
    output logic                 PANEL_NOTE_O,
    output logic                 BLOCK_EVENT_O,
    output ovt_pkg::volt_s       EVENT_VOLT_O,
    output logic [1:0]           EVENT_FAULT_O
);
    if (TICK_CYC < 2 || STAMP_CYC < 1) begin : g_bad_counts
        $error("Tick and stamp counts must be positive.");
    end

    // ----------------------------------------------------------------
    // Settings and bus
    // ----------------------------------------------------------------
    logic [31:0] mode_reg, mode_next;
    logic [15:0] fixed_reg, fixed_next, dial_reg, dial_next;
    logic [15:0] expo_reg, expo_next, rel_reg, rel_next;
    logic [31:0] dat_reg, dat_next;
    logic        ack_reg, ack_next;
    logic [31:0] stamp_reg, stamp_next;
    logic [31:0] stamp_div_reg, stamp_div_next;

    logic [19:0] optime_reg, optime_next, expect_reg, expect_next;
    logic [19:0] reltime_reg, reltime_next;
    logic [15:0] ra_reg, rb_reg, rc_reg, rm_reg;
    logic [15:0] ra_next, rb_next, rc_next, rm_next;
    logic        start_reg, trip_reg, blocked_reg;
    logic        pick_reg, pick_next;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    wire logic bus_req = WB_CYC_I && WB_STB_I && !ack_reg;

    always_comb begin
        mode_next  = mode_reg;
        fixed_next = fixed_reg;
        dial_next  = dial_reg;
        expo_next  = expo_reg;
        rel_next   = rel_reg;
        dat_next   = dat_reg;
        ack_next   = bus_req;
        stamp_div_next = stamp_div_reg + 32'h0000_0001;
        stamp_next = stamp_reg;
        if (stamp_div_reg >= 32'(STAMP_CYC - 1)) begin
            stamp_div_next = 32'h0000_0000;
            stamp_next     = stamp_reg + 32'h0000_0001;
        end
        if (bus_req && WB_WE_I) begin
            unique case (WB_ADR_I)
                ovt_pkg::OFF_MODE:  mode_next  = merge(mode_reg, WB_DAT_I, WB_SEL_I);
                ovt_pkg::OFF_FIXED: fixed_next = 16'(merge({16'h0000, fixed_reg}, WB_DAT_I,
                                                           WB_SEL_I));
                ovt_pkg::OFF_DIAL:  dial_next  = 16'(merge({16'h0000, dial_reg}, WB_DAT_I,
                                                           WB_SEL_I));
                ovt_pkg::OFF_EXPO:  expo_next  = 16'(merge({16'h0000, expo_reg}, WB_DAT_I,
                                                           WB_SEL_I));
                ovt_pkg::OFF_REL:   rel_next   = 16'(merge({16'h0000, rel_reg}, WB_DAT_I,
                                                           WB_SEL_I));
                default: ;
            endcase
        end
        if (bus_req) begin
            unique case (WB_ADR_I)
                ovt_pkg::OFF_MODE:   dat_next = mode_reg;
                ovt_pkg::OFF_FIXED:  dat_next = {16'h0000, fixed_reg};
                ovt_pkg::OFF_DIAL:   dat_next = {16'h0000, dial_reg};
                ovt_pkg::OFF_EXPO:   dat_next = {16'h0000, expo_reg};
                ovt_pkg::OFF_REL:    dat_next = {16'h0000, rel_reg};
                ovt_pkg::OFF_STATUS: dat_next = {28'h000_0000, pick_reg, blocked_reg,
                                                 trip_reg, start_reg};
                ovt_pkg::OFF_EXPECT: dat_next = {12'h000, expect_reg};
                ovt_pkg::OFF_REMAIN: dat_next = {12'h000, expect_reg - optime_reg};
                ovt_pkg::OFF_RATIO:  dat_next = {ra_reg, rb_reg};
                ovt_pkg::OFF_RATIOM: dat_next = {rc_reg, rm_reg};
                ovt_pkg::OFF_STAMP:  dat_next = stamp_reg;
                default:             dat_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            mode_reg      <= ovt_pkg::RST_MODE;
            fixed_reg     <= ovt_pkg::RST_FIXED;
            dial_reg      <= ovt_pkg::RST_DIAL;
            expo_reg      <= ovt_pkg::RST_EXPO;
            rel_reg       <= ovt_pkg::RST_REL;
            dat_reg       <= 32'h0000_0000;
            ack_reg       <= 1'b0;
            stamp_reg     <= 32'h0000_0000;
            stamp_div_reg <= 32'h0000_0000;
        end else begin
            mode_reg      <= mode_next;
            fixed_reg     <= fixed_next;
            dial_reg      <= dial_next;
            expo_reg      <= expo_next;
            rel_reg       <= rel_next;
            dat_reg       <= dat_next;
            ack_reg       <= ack_next;
            stamp_reg     <= stamp_next;
            stamp_div_reg <= stamp_div_next;
        end
    end

    // ----------------------------------------------------------------
    // Program-cycle tick and blocking sample
    // ----------------------------------------------------------------
    logic [31:0] tick_cnt_reg, tick_cnt_next;
    logic        tick_reg, tick_next;
    logic        blk_s1_reg, blk_s2_reg;
    logic        blk_reg, blk_next;

    wire logic [1:0] dtype = mode_reg[ovt_pkg::F_DTYPE +: 2];
    wire logic [1:0] drel  = mode_reg[ovt_pkg::F_DREL +: 2];
    wire logic [1:0] trst  = mode_reg[ovt_pkg::F_TRST +: 2];
    wire logic [1:0] cont  = mode_reg[ovt_pkg::F_CONT +: 2];
    wire logic [1:0] crit  = mode_reg[ovt_pkg::F_CRIT +: 2];

    always_comb begin
        tick_cnt_next = tick_cnt_reg + 32'h0000_0001;
        tick_next     = 1'b0;
        blk_next      = blk_reg;
        if (tick_cnt_reg >= 32'(TICK_CYC - 1)) begin
            tick_cnt_next = 32'h0000_0000;
            tick_next     = 1'b1;
        end
        // Blocking is latched on the same clock edge that raises the evaluation tick.
        if (tick_next) begin
            blk_next = mode_reg[ovt_pkg::F_FORCE] ? mode_reg[ovt_pkg::F_SWBLK]
                                                  : blk_s2_reg;
        end
    end

    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            tick_cnt_reg <= 32'h0000_0000;
            tick_reg     <= 1'b0;
            blk_s1_reg   <= 1'b0;
            blk_s2_reg   <= 1'b0;
            blk_reg      <= 1'b0;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
            tick_reg     <= tick_next;
            blk_s1_reg   <= BLOCK_PIN_I;
            blk_s2_reg   <= blk_s1_reg;
            blk_reg      <= blk_next;
        end
    end

    // ----------------------------------------------------------------
    // Pick-up, ratios and inverse time
    // ----------------------------------------------------------------
    function automatic logic [15:0] ratio(input logic [15:0] u, input logic [15:0] s);
        logic [31:0] q;
        q = (s == 16'h0000) ? 32'h0000_0000 : ({16'h0000, u} * 32'h0000_0064) / {16'h0000, s};
        return (q > 32'h0000_FFFF) ? 16'hFFFF : q[15:0];
    endfunction : ratio

    // Ratio raised to a/100, built from a piecewise product: accurate at integer exponents,
    // linear between them. A full real power is left to the protection CPU.
    function automatic logic [31:0] ratio_pow(input logic [15:0] r, input logic [15:0] a);
        logic [31:0] p;
        logic [31:0] lin;
        p = 32'h0000_0064;
        for (int i = 0; i < 25; i++) begin
            if ({16'h0000, a} >= 32'(100 * (i + 1)) && p < 32'h0100_0000) begin
                p = (p * {16'h0000, r}) / 32'h0000_0064;
            end
        end
        lin = (p * ({16'h0000, r} - 32'h0000_0064) * 32'({16'h0000, a} % 32'h0000_0064))
              / 32'h0000_2710;
        return p + lin;
    endfunction : ratio_pow

    // Pick-up compares raw voltages, so a truncated ratio cannot hide a small excess.
    function automatic logic held(input logic [15:0] u, input logic [15:0] s);
        return ({16'h0000, u} * 32'h0000_0064)
               >= ({16'h0000, s} * {16'h0000, ovt_pkg::RESET_PCT});
    endfunction : held

    logic [2:0] over, stay;
    logic [1:0] n_over, n_stay;
    logic       pick_set, pick_hold;
    logic [31:0] pw, inv_t;
    logic [19:0] expect_calc;

    always_comb begin
        ra_next = ratio(VOLT_I.ua, USET_I);
        rb_next = ratio(VOLT_I.ub, USET_I);
        rc_next = ratio(VOLT_I.uc, USET_I);
        rm_next = (ra_next > rb_next) ? ((ra_next > rc_next) ? ra_next : rc_next)
                                      : ((rb_next > rc_next) ? rb_next : rc_next);
        over = {VOLT_I.uc > USET_I, VOLT_I.ub > USET_I, VOLT_I.ua > USET_I};
        stay = {held(VOLT_I.uc, USET_I), held(VOLT_I.ub, USET_I), held(VOLT_I.ua, USET_I)};
        n_over = 2'({1'b0, over[0]} + {1'b0, over[1]} + {1'b0, over[2]});
        n_stay = 2'({1'b0, stay[0]} + {1'b0, stay[1]} + {1'b0, stay[2]});
        pick_set  = (over == 3'b111) || (n_over > crit);
        pick_hold = (stay == 3'b111) || (n_stay > crit);
        pick_next = pick_reg ? pick_hold : pick_set;
        pw = ratio_pow(rm_next, expo_reg);
        inv_t = (pw > 32'h0000_0064)
              ? ({16'h0000, dial_reg} * 32'h0000_00C8) / (pw - 32'h0000_0064)
              : {12'h000, ovt_pkg::MAX_TICKS};
        if (dtype == ovt_pkg::DT_INVERSE) begin
            expect_calc = (inv_t > {12'h000, ovt_pkg::MAX_TICKS}) ? ovt_pkg::MAX_TICKS
                                                                 : inv_t[19:0];
            if (rm_next <= ovt_pkg::RATIO_ONE) begin
                expect_calc = expect_reg;
            end
        end else begin
            expect_calc = {4'h0, fixed_reg};
        end
        expect_next = expect_calc;
    end

    // ----------------------------------------------------------------
    // Stage timing
    // ----------------------------------------------------------------
    logic start_next, trip_next, blocked_next, note_next;
    logic note_reg;
    ovt_pkg::volt_s evv_reg, evv_next;
    logic [1:0] evf_reg, evf_next;

    always_comb begin
        start_next   = start_reg;
        trip_next    = trip_reg;
        blocked_next = blocked_reg;
        optime_next  = optime_reg;
        reltime_next = reltime_reg;
        note_next    = 1'b0;
        evv_next     = evv_reg;
        evf_next     = evf_reg;
        if (tick_reg) begin
            if (pick_reg && blk_reg) begin
                blocked_next = 1'b1;
                if (!blocked_reg) begin
                    note_next = 1'b1;
                    evv_next  = VOLT_I;
                    evf_next  = 2'(n_over);
                end
                start_next = 1'b0;
                trip_next  = 1'b0;
            end else begin
                blocked_next = 1'b0;
            end
            if (pick_reg && !blk_reg) begin
                start_next   = 1'b1;
                reltime_next = 20'h0_0000;
                if (optime_reg + 20'h0_0001 >= expect_reg) begin
                    trip_next = 1'b1;
                end else begin
                    optime_next = optime_reg + 20'h0_0001;
                end
                if (expect_reg == 20'h0_0000) begin
                    trip_next = 1'b1;
                end
            end else if (!pick_reg || blk_reg) begin
                trip_next = 1'b0;
                if (reltime_reg < {4'h0, rel_reg}) begin
                    reltime_next = reltime_reg + 20'h0_0001;
                    if (cont == ovt_pkg::CODE_YES && optime_reg < expect_reg) begin
                        optime_next = optime_reg + 20'h0_0001;
                    end
                    if (drel != ovt_pkg::CODE_YES) begin
                        start_next = 1'b0;
                    end
                    if (trst != ovt_pkg::CODE_YES) begin
                        optime_next = 20'h0_0000;
                    end
                end else begin
                    start_next  = 1'b0;
                    optime_next = 20'h0_0000;
                end
                if (blk_reg) begin
                    start_next = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            pick_reg    <= 1'b0;
            ra_reg      <= 16'h0000;
            rb_reg      <= 16'h0000;
            rc_reg      <= 16'h0000;
            rm_reg      <= 16'h0000;
            expect_reg  <= {4'h0, ovt_pkg::RST_FIXED};
            optime_reg  <= 20'h0_0000;
            reltime_reg <= 20'h0_0000;
            start_reg   <= 1'b0;
            trip_reg    <= 1'b0;
            blocked_reg <= 1'b0;
            note_reg    <= 1'b0;
            evv_reg     <= '0;
            evf_reg     <= 2'h0;
        end else begin
            pick_reg    <= pick_next;
            ra_reg      <= ra_next;
            rb_reg      <= rb_next;
            rc_reg      <= rc_next;
            rm_reg      <= rm_next;
            expect_reg  <= expect_next;
            optime_reg  <= optime_next;
            reltime_reg <= reltime_next;
            start_reg   <= start_next;
            trip_reg    <= trip_next;
            blocked_reg <= blocked_next;
            note_reg    <= note_next;
            evv_reg     <= evv_next;
            evf_reg     <= evf_next;
        end
    end

    assign WB_DAT_O      = dat_reg;
    assign WB_ACK_O      = ack_reg;
    assign START_O       = start_reg;
    assign TRIP_O        = trip_reg;
    assign BLOCKED_O     = blocked_reg;
    assign PANEL_NOTE_O  = note_reg;
    assign BLOCK_EVENT_O = note_reg;
    assign EVENT_VOLT_O  = evv_reg;
    assign EVENT_FAULT_O = evf_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_trip_needs_start: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        TRIP_O |-> START_O) else $error("Trip without start.");
    chk_blocked_no_start: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        BLOCKED_O |-> !START_O) else $error("Start while blocked.");
    chk_block_drops: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        (tick_reg && blk_reg && pick_reg) |=> !START_O) else $error("Start kept.");
    chk_start_on_pick: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        (tick_reg && pick_reg && !blk_reg) |=> START_O) else $error("No start.");
    chk_note_pulse: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        PANEL_NOTE_O |-> BLOCKED_O && !$past(blocked_reg)) else $error("Bad note.");
    chk_timer_moves_tick: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        !tick_reg |=> $stable(optime_reg)) else $error("Timer off tick.");
    chk_no_trip_release: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        (tick_reg && !pick_reg) |=> !TRIP_O) else $error("Trip in release.");
    chk_sample_source: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        (tick_next && !mode_reg[ovt_pkg::F_FORCE]) |=> blk_reg == $past(blk_s2_reg))
        else $error("Blocking sample wrong.");
    chk_clamp: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        expect_reg <= ovt_pkg::MAX_TICKS) else $error("Time above clamp.");
    cov_trip: cover property (@(posedge MCLK_I) $rose(TRIP_O));
    cov_block: cover property (@(posedge MCLK_I) $rose(BLOCKED_O));
    cov_release: cover property (@(posedge MCLK_I) $fell(START_O));
endmodule : ovt_stage

/* verif/blk_matrix.sv */
/* Blocking matrix model that drives the stage's external blocking line.
 * Assumes the clock of the stage; the line is a plain level with no pull. */
`timescale 1ns/100ps
module blk_matrix (
    // Clock and request
    input  wire logic       clk_i,
    input  wire logic       want_i,
    input  wire logic [3:0] lag_i,
    // Blocking line
    output logic            block_o
);
    logic [3:0] cnt_reg;
    // The bench raises the request long before any trip delay runs out.
    always_ff @(posedge clk_i) begin
        cnt_reg <= want_i ? ((cnt_reg == lag_i) ? cnt_reg : cnt_reg + 4'h1) : 4'h0;
        block_o <= want_i && (cnt_reg == lag_i);
    end
endmodule : blk_matrix

/* verif/overvoltage_trip_timing_test.sv */
/* Self-checking bench for the overvoltage stage; bus reads are checked from a queue.
 * Assumes the blocking matrix model and a program cycle shortened to ten clocks. */
`timescale 1ns/100ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin mismatches++; \
$display("[FAIL] %s exp %h got %h", n, e, s); end end
module overvoltage_trip_timing_test;
    logic           clk, rst, cyc, stb, we, want, ack, start, trip, bev, block, note, blkd;
    logic [1:0]     evf;
    logic [7:0]     adr;
    logic [31:0]    dat, rdat, e_v;
    logic [15:0]    uset, ua_v, e_r;
    ovt_pkg::volt_s volt, evv;
    logic [31:0]    exp_q[$];
    int             mismatches, samples_checked, cycles, ev_n, n;
    ovt_stage #(.TICK_CYC(10), .STAMP_CYC(5)) uut (
        .MCLK_I(clk), .RESET_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .VOLT_I(volt), .USET_I(uset), .BLOCK_PIN_I(block), .START_O(start), .TRIP_O(trip),
        .BLOCKED_O(blkd), .PANEL_NOTE_O(note), .BLOCK_EVENT_O(bev), .EVENT_VOLT_O(evv),
        .EVENT_FAULT_O(evf));
    blk_matrix bm (.clk_i(clk), .want_i(want), .lag_i(4'h3), .block_o(block));
    // ----------------------------------------------------------------
    // Clock, timeout and output watcher
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            results();
        end
    end
    always @(negedge clk) begin
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
            e_v = exp_q.pop_front();
            `CHK("rdata", e_v, rdat)
        end
        if (bev === 1'b1) begin
            ev_n++;
            `CHK("panel_note", 1'b1, note)
            `CHK("event_fault", 2'h1, evf)
            `CHK("event_volt", volt, evv)
        end
    end
    // ----------------------------------------------------------------
    // Bus and stimulus tasks
    // ----------------------------------------------------------------
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        do @(posedge clk); while (ack !== 1'b1);
        {cyc, stb} <= 2'b00;
        @(posedge clk);
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, 32'h0000_0000);
    endtask : rd
    task automatic tk(input int c);
        repeat (c) @(posedge clk);
    endtask : tk
    task automatic hi();
        ua_v = 16'h03E9 + 16'($urandom % 500);
        e_r  = 16'(({16'h0000, ua_v} * 32'h0000_0064) / {16'h0000, uset});
        volt.ua <= ua_v;
    endtask : hi
    task automatic lo();
        volt.ua <= 16'h03C0 - 16'($urandom % 64);
    endtask : lo
    task results();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {rst, cyc, stb, we, want} = 5'b10000;
        adr = 8'h00;
        dat = 32'h0000_0000;
        uset = 16'h03E8;
        volt = '0;
        void'($urandom(47128));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(ovt_pkg::OFF_MODE, ovt_pkg::RST_MODE);
        rd(ovt_pkg::OFF_FIXED, {16'h0000, ovt_pkg::RST_FIXED});
        rd(ovt_pkg::OFF_REL, {16'h0000, ovt_pkg::RST_REL});
        rd(8'hFC, 32'h0000_0000);
        hi();
        tk(45);
        rd(ovt_pkg::OFF_STATUS, 32'h0000_0009);
        rd(ovt_pkg::OFF_EXPECT, 32'h0000_0008);
        rd(ovt_pkg::OFF_RATIO, {e_r, 16'h0000});
        rd(ovt_pkg::OFF_RATIOM, {16'h0000, e_r});
        tk(100);
        rd(ovt_pkg::OFF_STATUS, 32'h0000_000B);
        lo();
        tk(30);
        rd(ovt_pkg::OFF_STATUS, 32'h0000_0000);
        wb(1'b1, ovt_pkg::OFF_FIXED, 32'h0000_0000);
        hi();
        n = 0;
        while (start !== 1'b1 && n < 100) begin @(negedge clk); n++; end
        `CHK("trip", 1'b1, trip)
        lo();
        tk(30);
        want <= 1'b1;
        tk(30);
        hi();
        tk(40);
        rd(ovt_pkg::OFF_STATUS, 32'h0000_000C);
        `CHK("blocked", 1'b1, blkd)
        `CHK("block_events", 1, ev_n)
        wb(1'b1, ovt_pkg::OFF_MODE, ovt_pkg::RST_MODE | (32'h0000_0001 << ovt_pkg::F_FORCE)
                                    | (32'h0000_0001 << ovt_pkg::F_SWBLK));
        want <= 1'b0;
        tk(40);
        rd(ovt_pkg::OFF_STATUS, 32'h0000_000C);
        wb(1'b1, ovt_pkg::OFF_MODE, ovt_pkg::RST_MODE | (32'h0000_0001 << ovt_pkg::F_FORCE));
        tk(30);
        rd(ovt_pkg::OFF_STATUS, 32'h0000_000B);
        `CHK("block_events_end", 1, ev_n)
        results();
    end
endmodule : overvoltage_trip_timing_test
